// ---- drive_prot_pkg.sv ----
// Purpose: Shared constants and types for the drive bus and current protection block.
// Assumes: Voltages are in units of 0.1 V and currents in whole percent of rated current.
// Notes: Register offsets are byte addresses on the plain register port.
package drive_prot_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_UV_LEVEL = 8'h00;
   localparam logic [7:0] OFS_OV_LEVEL = 8'h04;
   localparam logic [7:0] OFS_OV_MODE = 8'h08;
   localparam logic [7:0] OFS_ACC_LIMIT = 8'h0c;
   localparam logic [7:0] OFS_RUN_LIMIT = 8'h10;
   localparam logic [7:0] OFS_RAMP_SEL = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
   localparam logic [7:0] OFS_STATE = 8'h20;
   // Undervoltage level, defaults and ranges per voltage class, in 0.1 V.
   localparam logic [15:0] UV_DEF_LO = 16'h0708;
   localparam logic [15:0] UV_DEF_HI = 16'h0e10;
   localparam logic [15:0] UV_MIN_LO = 16'h05dc;
   localparam logic [15:0] UV_MAX_LO = 16'h0898;
   localparam logic [15:0] UV_MIN_HI = 16'h0bb8;
   localparam logic [15:0] UV_MAX_HI = 16'h1130;
   localparam logic [15:0] UV_STOP_MARGIN = 16'h0258;
   // Overvoltage stall level, defaults and upper bounds per class, in 0.1 V.
   localparam logic [15:0] OV_DEF_LO = 16'h0ed8;
   localparam logic [15:0] OV_DEF_HI = 16'h1db0;
   localparam logic [15:0] OV_MAX_LO = 16'h1194;
   localparam logic [15:0] OV_MAX_HI = 16'h2328;
   localparam logic [15:0] OV_OFF = 16'h0000;
   // Current limits in percent, where 100 is the rated current.
   localparam logic [15:0] CUR_LIMIT_DEF = 16'h00b4;
   localparam logic [15:0] CUR_LIMIT_MAX = 16'h00c8;
   localparam logic [15:0] CUR_RATED = 16'h0064;
   // Selector encodings and resets.
   localparam logic OV_MODE_TRAD = 1'h0;
   localparam logic OV_MODE_SMART = 1'h1;
   localparam logic [2:0] RAMP_PRESENT = 3'h0;
   localparam logic [2:0] RAMP_AUTO = 3'h5;
   localparam logic [15:0] OV_MODE_RST = 16'h0000;
   localparam logic [15:0] RAMP_SEL_RST = 16'h0000;
   // Interrupt status bit positions.
   localparam int IRQ_UV_RUN = 0;
   localparam int IRQ_UV_STOP = 1;
   localparam int IRQ_OV_STALL = 2;
   localparam int IRQ_ACC_STALL = 3;
   localparam int IRQ_RUN_STALL = 4;
   localparam int IRQ_W = 5;
   localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
   // State register field positions.
   localparam int ST_CODE_LSB = 0;
   localparam int ST_HOLD = 4;
   localparam int ST_LOWER = 5;
   localparam int ST_REGULATE = 6;
   localparam int ST_CUT = 7;

   typedef enum logic [2:0] {
      FC_NONE,
      FC_UV_ACCEL,
      FC_UV_DECEL,
      FC_UV_CONST,
      FC_UV_STOP
   } fault_code_t;
endpackage : drive_prot_pkg

// ---- drive_bus_current_protection.sv ----
// Purpose: Undervoltage fault, overvoltage stall and overcurrent stall supervisor.
// Assumes: Measurements, phase flags and reset command come from logic on clk_sys.
// Notes: The voltage class select is a pin and is synchronised before use.
`timescale 1ns/1ps
`default_nettype none

// Contract
// [R1] A bus voltage below the undervoltage level raises a fault that cuts output so the motor coasts.
// [R2] A running undervoltage fault carries an accelerating, decelerating or constant-speed code.
// [R3] A running undervoltage fault stays latched until a reset command is given.
// [R4] An undervoltage while stopped shows its own code, is not logged, and clears above level plus 60 V.
// [R5] The undervoltage level defaults to 180.0 V or 360.0 V and is held within 150.0-220.0 V or 300.0-440.0 V.
// [R6] An overvoltage stall level of 0.0 disables overvoltage stall prevention, any other value is the trip point.
// [R7] The overvoltage stall level defaults to 380.0 V or 760.0 V and is held within 0.0-450.0 V or 0.0-900.0 V.
// [R8] Mode 0 treats bus rise during deceleration as the overvoltage stall condition.
// [R9] In mode 0 the frequency is frozen while the bus is above the level and deceleration resumes below it.
// [R10] In mode 1 deceleration is regulated so the bus voltage is held steady.
// [R11] While accelerating above the acceleration current limit, default 180, the frequency is held.
// [R12] At constant speed above the running current limit the frequency is lowered, then ramped back up below it.
// [R13] Current limits are percentages where 100 equals rated output current.
// [R14] The ramp selector decodes 0 as present ramp, 1 to 4 as ramp sets and 5 as automatic.
// [R15] Comparisons use the sample of one control cycle and act in the following cycle.
module drive_bus_current_protection (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Measurement path and run status.
   input wire logic sample_valid,
   input wire logic [15:0] bus_voltage,
   input wire logic [15:0] output_current_pct,
   input wire logic running,
   input wire logic accelerating,
   input wire logic decelerating,
   input wire logic fault_reset_cmd,
   input wire logic high_voltage_class,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Power stage actions.
   output logic output_cut,
   output logic undervoltage_fault,
   output logic [2:0] fault_code,
   output logic fault_log,
   output logic freq_hold,
   output logic freq_lower,
   output logic decel_regulate,
   output logic [2:0] stall_ramp_set,
   output logic stall_ramp_auto,
   // Interrupt.
   output logic irq
);
   typedef struct packed {
      logic class_meta;
      logic class_sync;
      logic [15:0] uv_level;
      logic uv_written;
      logic [15:0] ov_level;
      logic ov_written;
      logic ov_mode;
      logic [15:0] acc_limit;
      logic [15:0] run_limit;
      logic [2:0] ramp_sel;
      logic [drive_prot_pkg::IRQ_W-1:0] irq_status;
      logic [drive_prot_pkg::IRQ_W-1:0] irq_mask;
      logic [31:0] rdata;
      logic smp;
      logic [15:0] volt;
      logic [15:0] cur;
      logic smp_run;
      logic smp_acc;
      logic smp_dec;
      drive_prot_pkg::fault_code_t code;
      logic log_pulse;
      logic ov_hold;
      logic acc_hold;
      logic run_lower;
      logic regulate;
   } state_t;

   state_t q;
   state_t next_q;

   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
      if (v < lo) begin
         return lo;
      end else if (v > hi) begin
         return hi;
      end
      return v;
   endfunction : clamp16

   function automatic logic [15:0] pick(input logic wr, input logic [15:0] val,
                                        input logic [15:0] def);
      return wr ? val : def;
   endfunction : pick

   logic [15:0] uv_eff;
   logic [15:0] ov_eff;
   logic uv_low;
   logic uv_recovered;
   logic ov_active;
   logic [drive_prot_pkg::IRQ_W-1:0] irq_set;

   // Class defaults apply until software writes a level, since a reset value cannot follow a pin.
   assign uv_eff = pick(q.uv_written, q.uv_level,
                        q.class_sync ? drive_prot_pkg::UV_DEF_HI : drive_prot_pkg::UV_DEF_LO); // see [R5]
   assign ov_eff = pick(q.ov_written, q.ov_level,
                        q.class_sync ? drive_prot_pkg::OV_DEF_HI : drive_prot_pkg::OV_DEF_LO); // see [R7]
   assign uv_low = q.smp && (q.volt < uv_eff); // see [R15]
   assign uv_recovered = q.smp && ({1'b0, q.volt} > ({1'b0, uv_eff} +
                         {1'b0, drive_prot_pkg::UV_STOP_MARGIN})); // see [R4]
   // Overvoltage stall is armed only during deceleration with a non-zero level.
   assign ov_active = q.smp && q.smp_dec && (ov_eff != drive_prot_pkg::OV_OFF)
                      && (q.volt > ov_eff); // see [R6] see [R8]

   always_comb begin
      next_q = q;
      irq_set = '0;
      next_q.class_meta = high_voltage_class;
      next_q.class_sync = q.class_meta;
      next_q.log_pulse = 1'b0;
      next_q.rdata = 32'h0000_0000;
      // Sample capture; decisions are made from the captured copy one cycle later.
      next_q.smp = sample_valid; // see [R15]
      if (sample_valid) begin
         next_q.volt = bus_voltage;
         next_q.cur = output_current_pct;
         next_q.smp_run = running;
         next_q.smp_acc = accelerating;
         next_q.smp_dec = decelerating;
      end

      // Undervoltage handling.
      if (q.code != drive_prot_pkg::FC_NONE && q.code != drive_prot_pkg::FC_UV_STOP
          && fault_reset_cmd) begin
         next_q.code = drive_prot_pkg::FC_NONE; // see [R3]
      end
      if (q.code == drive_prot_pkg::FC_UV_STOP && uv_recovered) begin
         next_q.code = drive_prot_pkg::FC_NONE; // see [R4]
      end
      if (uv_low && q.smp_run && (q.code == drive_prot_pkg::FC_NONE
          || q.code == drive_prot_pkg::FC_UV_STOP || fault_reset_cmd)) begin
         // A new fault beats a reset command given in the same cycle.
         if (q.smp_acc) begin
            next_q.code = drive_prot_pkg::FC_UV_ACCEL; // see [R2]
         end else if (q.smp_dec) begin
            next_q.code = drive_prot_pkg::FC_UV_DECEL; // see [R2]
         end else begin
            next_q.code = drive_prot_pkg::FC_UV_CONST; // see [R2]
         end
         next_q.log_pulse = 1'b1; // see [R1]
         irq_set[drive_prot_pkg::IRQ_UV_RUN] = 1'b1;
      end else if (uv_low && !q.smp_run && q.code == drive_prot_pkg::FC_NONE) begin
         next_q.code = drive_prot_pkg::FC_UV_STOP; // see [R4]
         irq_set[drive_prot_pkg::IRQ_UV_STOP] = 1'b1;
      end

      // Stall prevention, updated once per sample.
      if (q.smp) begin
         next_q.ov_hold = ov_active && (q.ov_mode == drive_prot_pkg::OV_MODE_TRAD); // see [R9]
         next_q.regulate = ov_active && (q.ov_mode == drive_prot_pkg::OV_MODE_SMART); // see [R10]
         next_q.acc_hold = q.smp_run && q.smp_acc && (q.cur > q.acc_limit); // see [R11] see [R13]
         next_q.run_lower = q.smp_run && !q.smp_acc && !q.smp_dec
                            && (q.cur > q.run_limit); // see [R12] see [R13]
         if (ov_active && !(q.ov_hold || q.regulate)) begin
            irq_set[drive_prot_pkg::IRQ_OV_STALL] = 1'b1;
         end
         if (next_q.acc_hold && !q.acc_hold) begin
            irq_set[drive_prot_pkg::IRQ_ACC_STALL] = 1'b1;
         end
         if (next_q.run_lower && !q.run_lower) begin
            irq_set[drive_prot_pkg::IRQ_RUN_STALL] = 1'b1;
         end
      end

      // Register writes; levels are clamped into the range of the present class.
      if (reg_wr) begin
         case (reg_addr)
            drive_prot_pkg::OFS_UV_LEVEL: begin
               next_q.uv_written = 1'b1;
               next_q.uv_level = q.class_sync ?
                  clamp16(reg_wdata[15:0], drive_prot_pkg::UV_MIN_HI, drive_prot_pkg::UV_MAX_HI) :
                  clamp16(reg_wdata[15:0], drive_prot_pkg::UV_MIN_LO,
                          drive_prot_pkg::UV_MAX_LO); // see [R5]
            end
            drive_prot_pkg::OFS_OV_LEVEL: begin
               next_q.ov_written = 1'b1;
               next_q.ov_level = clamp16(reg_wdata[15:0], drive_prot_pkg::OV_OFF,
                  q.class_sync ? drive_prot_pkg::OV_MAX_HI : drive_prot_pkg::OV_MAX_LO); // see [R7]
            end
            drive_prot_pkg::OFS_OV_MODE: begin
               next_q.ov_mode = reg_wdata[0];
            end
            drive_prot_pkg::OFS_ACC_LIMIT: begin
               next_q.acc_limit = clamp16(reg_wdata[15:0], 16'h0000, drive_prot_pkg::CUR_LIMIT_MAX);
            end
            drive_prot_pkg::OFS_RUN_LIMIT: begin
               next_q.run_limit = clamp16(reg_wdata[15:0], 16'h0000, drive_prot_pkg::CUR_LIMIT_MAX);
            end
            drive_prot_pkg::OFS_RAMP_SEL: begin
               // Codes above automatic are ignored so the selector always decodes.
               if (reg_wdata[15:0] <= {13'h0000, drive_prot_pkg::RAMP_AUTO}) begin
                  next_q.ramp_sel = reg_wdata[2:0]; // see [R14]
               end
            end
            drive_prot_pkg::OFS_IRQ_MASK: begin
               next_q.irq_mask = reg_wdata[drive_prot_pkg::IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // Write-one-to-clear, with a same-cycle event winning over the clear.
      if (reg_wr && reg_addr == drive_prot_pkg::OFS_IRQ_STATUS) begin
         next_q.irq_status = (q.irq_status & ~reg_wdata[drive_prot_pkg::IRQ_W-1:0]) | irq_set;
      end else begin
         next_q.irq_status = q.irq_status | irq_set;
      end

      // Register reads; data stands only in the cycle after the strobe.
      if (reg_rd) begin
         case (reg_addr)
            drive_prot_pkg::OFS_UV_LEVEL: next_q.rdata = {16'h0000, uv_eff};
            drive_prot_pkg::OFS_OV_LEVEL: next_q.rdata = {16'h0000, ov_eff};
            drive_prot_pkg::OFS_OV_MODE: next_q.rdata = {31'h0000_0000, q.ov_mode};
            drive_prot_pkg::OFS_ACC_LIMIT: next_q.rdata = {16'h0000, q.acc_limit};
            drive_prot_pkg::OFS_RUN_LIMIT: next_q.rdata = {16'h0000, q.run_limit};
            drive_prot_pkg::OFS_RAMP_SEL: next_q.rdata = {29'h0000_0000, q.ramp_sel};
            drive_prot_pkg::OFS_IRQ_STATUS: next_q.rdata = {27'h000_0000, q.irq_status};
            drive_prot_pkg::OFS_IRQ_MASK: next_q.rdata = {27'h000_0000, q.irq_mask};
            drive_prot_pkg::OFS_STATE: begin
               next_q.rdata = 32'h0000_0000;
               next_q.rdata[drive_prot_pkg::ST_CODE_LSB +: 3] = q.code;
               next_q.rdata[drive_prot_pkg::ST_HOLD] = q.ov_hold | q.acc_hold;
               next_q.rdata[drive_prot_pkg::ST_LOWER] = q.run_lower;
               next_q.rdata[drive_prot_pkg::ST_REGULATE] = q.regulate;
               next_q.rdata[drive_prot_pkg::ST_CUT] = q.code != drive_prot_pkg::FC_NONE;
            end
            default: next_q.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.code <= drive_prot_pkg::FC_NONE;
         q.ov_mode <= drive_prot_pkg::OV_MODE_RST[0];
         q.acc_limit <= drive_prot_pkg::CUR_LIMIT_DEF;
         q.run_limit <= drive_prot_pkg::CUR_LIMIT_DEF;
         q.ramp_sel <= drive_prot_pkg::RAMP_SEL_RST[2:0];
         q.irq_status <= drive_prot_pkg::IRQ_RST;
         q.irq_mask <= drive_prot_pkg::IRQ_RST;
      end else begin
         q <= next_q;
      end
   end

   assign reg_rdata = q.rdata;
   assign output_cut = (q.code != drive_prot_pkg::FC_NONE); // see [R1]
   assign undervoltage_fault = (q.code != drive_prot_pkg::FC_NONE);
   assign fault_code = q.code;
   assign fault_log = q.log_pulse;
   assign freq_hold = q.ov_hold | q.acc_hold;
   assign freq_lower = q.run_lower;
   assign decel_regulate = q.regulate;
   assign stall_ramp_set = q.ramp_sel;
   assign stall_ramp_auto = (q.ramp_sel == drive_prot_pkg::RAMP_AUTO); // see [R14]
   assign irq = |(q.irq_status & q.irq_mask);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Sample checks watch the registered sample, so each consequent lands one cycle after it.

   uv_run_accel_a: assert property ( // see [R2]
      q.smp && q.volt < uv_eff && q.smp_run && q.smp_acc && q.code == drive_prot_pkg::FC_NONE
      |=> fault_code == drive_prot_pkg::FC_UV_ACCEL && fault_log && output_cut)
      else $error("Accelerating undervoltage not reported.");
   uv_run_latch_a: assert property ( // see [R3]
      (q.code == drive_prot_pkg::FC_UV_CONST || q.code == drive_prot_pkg::FC_UV_DECEL)
      && !fault_reset_cmd |=> $stable(fault_code))
      else $error("Running undervoltage fault cleared without reset.");
   uv_reset_clear_a: assert property ( // see [R3]
      q.code == drive_prot_pkg::FC_UV_ACCEL && fault_reset_cmd && !q.smp
      |=> fault_code == drive_prot_pkg::FC_NONE)
      else $error("Reset command did not clear the fault.");
   uv_stop_entry_a: assert property ( // see [R4]
      q.smp && q.volt < uv_eff && !q.smp_run && q.code == drive_prot_pkg::FC_NONE
      |=> fault_code == drive_prot_pkg::FC_UV_STOP && !fault_log)
      else $error("Stop undervoltage handled wrongly.");
   uv_stop_clear_a: assert property ( // see [R4]
      q.code == drive_prot_pkg::FC_UV_STOP && q.smp && !q.smp_run
      && {1'b0, q.volt} > {1'b0, uv_eff} + {1'b0, drive_prot_pkg::UV_STOP_MARGIN}
      |=> fault_code == drive_prot_pkg::FC_NONE)
      else $error("Stop undervoltage did not clear.");
   ov_disabled_a: assert property ( // see [R6]
      ov_eff == drive_prot_pkg::OV_OFF && q.smp |=> !q.ov_hold && !decel_regulate)
      else $error("Overvoltage stall acted while disabled.");
   ov_freeze_a: assert property ( // see [R9]
      q.smp && q.smp_dec && q.ov_mode == drive_prot_pkg::OV_MODE_TRAD && ov_eff != 16'h0000
      && q.volt > ov_eff |=> freq_hold && !decel_regulate)
      else $error("Traditional overvoltage stall did not freeze.");
   ov_smart_a: assert property ( // see [R10]
      q.smp && q.smp_dec && q.ov_mode == drive_prot_pkg::OV_MODE_SMART && ov_eff != 16'h0000
      && q.volt > ov_eff |=> decel_regulate)
      else $error("Smart overvoltage stall did not regulate.");
   acc_stall_a: assert property ( // see [R11]
      q.smp && q.smp_run && q.smp_acc && q.cur > q.acc_limit |=> freq_hold)
      else $error("Acceleration stall did not hold frequency.");
   run_stall_a: assert property ( // see [R12]
      q.smp && q.smp_run && !q.smp_acc && !q.smp_dec |=> freq_lower == $past(q.cur > q.run_limit))
      else $error("Running stall lowering wrong.");
   ramp_range_a: assert property ( // see [R14]
      stall_ramp_set <= drive_prot_pkg::RAMP_AUTO)
      else $error("Ramp selector out of range.");
   uv_level_range_a: assert property ( // see [R5]
      uv_eff >= drive_prot_pkg::UV_MIN_LO && uv_eff <= drive_prot_pkg::UV_MAX_HI)
      else $error("Undervoltage level out of range.");
   ov_resume_a: assert property ( // see [R9]
      q.smp && q.smp_dec && !q.smp_acc && q.volt <= ov_eff |=> !freq_hold && !decel_regulate)
      else $error("Overvoltage stall did not release.");
   acc_resume_a: assert property ( // see [R11]
      q.smp && q.smp_acc && !q.smp_dec && q.cur <= q.acc_limit |=> !freq_hold)
      else $error("Acceleration stall did not release.");
   stop_no_log_a: assert property ( // see [R4]
      fault_code == drive_prot_pkg::FC_UV_STOP |-> !fault_log)
      else $error("Stop undervoltage was logged.");
   acc_no_lower_a: assert property ( // see [R12]
      q.smp && q.smp_acc |=> !freq_lower)
      else $error("Frequency lowered during acceleration.");

   uv_fault_c: cover property (fault_code == drive_prot_pkg::FC_UV_DECEL ##1 fault_reset_cmd);
   stop_uv_c: cover property (fault_code == drive_prot_pkg::FC_UV_STOP
      ##[1:50] fault_code == drive_prot_pkg::FC_NONE);
   ov_hold_c: cover property (q.ov_hold ##1 !q.ov_hold);
   run_stall_c: cover property (freq_lower ##[1:20] !freq_lower);
   acc_hold_c: cover property (q.acc_hold ##1 !q.acc_hold);
endmodule : drive_bus_current_protection

`default_nettype wire

// ---- drive_stage_model.sv ----
// Purpose: Power stage measurement model feeding the protection block.
// Assumes: The bench asks for one sample per go pulse.
// Notes: Off-sample voltage and current lines toggle each cycle, so a stray capture shows.
`timescale 1ns/1ps
`default_nettype none
module drive_stage_model (
   // Clock, reset and bench request.
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic go,
   input wire logic [15:0] volt,
   input wire logic [15:0] amp,
   input wire logic [2:0] phase,
   // Measurements.
   output logic sample_valid,
   output logic [15:0] bus_voltage,
   output logic [15:0] output_current_pct,
   output logic running,
   output logic accelerating,
   output logic decelerating
);
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sample_valid <= 1'b0;
         bus_voltage <= 16'h0000;
         output_current_pct <= 16'h0000;
         {running, accelerating, decelerating} <= 3'h0;
      end else if (go) begin
         sample_valid <= 1'b1;
         bus_voltage <= volt;
         output_current_pct <= amp;
         {running, accelerating, decelerating} <= phase;
      end else begin
         sample_valid <= 1'b0;
         bus_voltage <= ~bus_voltage;
         output_current_pct <= ~output_current_pct;
      end
   end
endmodule : drive_stage_model
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the protection supervisor.
// Assumes: Lower voltage class until a mid-run reset switches to the higher class.
// Notes: Outputs are checked once a sample has fully settled.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic go = 1'b0;
   logic [15:0] volt = 16'h0000;
   logic [15:0] amp = 16'h0000;
   logic [2:0] phase = 3'h0;
   logic fault_reset_cmd = 1'b0;
   logic hv_class = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sample_valid, running, accelerating, decelerating;
   logic [15:0] bus_voltage, output_current_pct;
   logic [31:0] reg_rdata;
   logic output_cut, undervoltage_fault, fault_log, freq_hold, freq_lower;
   logic decel_regulate, stall_ramp_auto, irq;
   logic [2:0] fault_code, stall_ramp_set;
   logic [2:0] ph [3] = '{3'b110, 3'b101, 3'b100};
   int fails = 0;
   int comparisons = 0;
   int logs;
   always #2.5 clk_sys = ~clk_sys;
   drive_stage_model i_drive_stage_model (.clk_sys(clk_sys), .arst_n(arst_n),
      .go(go), .volt(volt), .amp(amp), .phase(phase), .sample_valid(sample_valid),
      .bus_voltage(bus_voltage), .output_current_pct(output_current_pct),
      .running(running), .accelerating(accelerating), .decelerating(decelerating));
   drive_bus_current_protection i_drive_bus_current_protection (.clk_sys(clk_sys),
      .arst_n(arst_n), .sample_valid(sample_valid), .bus_voltage(bus_voltage),
      .output_current_pct(output_current_pct), .running(running),
      .accelerating(accelerating), .decelerating(decelerating),
      .fault_reset_cmd(fault_reset_cmd), .high_voltage_class(hv_class),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .output_cut(output_cut),
      .undervoltage_fault(undervoltage_fault), .fault_code(fault_code),
      .fault_log(fault_log), .freq_hold(freq_hold), .freq_lower(freq_lower),
      .decel_regulate(decel_regulate), .stall_ramp_set(stall_ramp_set),
      .stall_ramp_auto(stall_ramp_auto), .irq(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rd
   // Logs counts fault_log cycles, so a stuck or missing pulse both show.
   task automatic smp(input logic [15:0] v, input logic [15:0] a, input logic [2:0] p);
      @(posedge clk_sys);
      go <= 1'b1;
      volt <= v;
      amp <= a;
      phase <= p;
      @(posedge clk_sys);
      go <= 1'b0;
      logs = 0;
      repeat (5) begin
         @(posedge clk_sys);
         #1 logs += (fault_log === 1'b1);
      end
   endtask : smp
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #50000;
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(8'h00, 32'h0708);
      rd(8'h04, 32'h0ed8);
      rd(8'h08, 32'h0);
      rd(8'h0c, 32'hb4);
      rd(8'h10, 32'hb4);
      rd(8'h14, 32'h0);
      rd(8'h40, 32'h0);
      wr(8'h00, 32'h0100);
      rd(8'h00, 32'h05dc);
      wr(8'h00, 32'h1000);
      rd(8'h00, 32'h0898);
      wr(8'h00, 32'h0708);
      wr(8'h04, 32'hffff);
      rd(8'h04, 32'h1194);
      wr(8'h04, 32'h0ed8);
      $display("Test registers done");
      wr(8'h1c, 32'h1f);
      for (int i = 0; i < 3; i++) begin
         smp(16'h0707, 16'h0, ph[i]);
         chk(32'(fault_code), 32'(i + 1));
         chk({30'h0, output_cut, undervoltage_fault}, 32'h3);
         chk(32'(logs), 32'h1);
         chk(32'(irq), 32'h1);
         rd(8'h20, 32'h80 | 32'(i + 1));
         rd(8'h18, 32'h1);
         smp(16'h0800, 16'h0, ph[i]);
         chk(32'(fault_code), 32'(i + 1));
         @(posedge clk_sys);
         fault_reset_cmd <= 1'b1;
         @(posedge clk_sys);
         fault_reset_cmd <= 1'b0;
         repeat (2) @(posedge clk_sys);
         #1 chk(32'(fault_code), 32'h0);
         wr(8'h18, 32'h1f);
         #1 chk(32'(irq), 32'h0);
      end
      $display("Test running undervoltage done");
      wr(8'h1c, 32'h0);
      smp(16'h0707, 16'h0, 3'b000);
      chk(32'(fault_code), 32'h4);
      chk(32'(logs), 32'h0);
      chk(32'(irq), 32'h0);
      rd(8'h18, 32'h2);
      rd(8'h20, 32'h84);
      smp(16'h0960, 16'h0, 3'b000);
      chk(32'(fault_code), 32'h4);
      smp(16'h0961, 16'h0, 3'b000);
      chk(32'(fault_code), 32'h0);
      wr(8'h18, 32'h1f);
      $display("Test stop undervoltage done");
      smp(16'h0ed9, 16'h0, 3'b101);
      chk({freq_hold, decel_regulate}, 2'b10);
      smp(16'h0ed8, 16'h0, 3'b101);
      chk(32'(freq_hold), 32'h0);
      smp(16'h0f00, 16'h0, 3'b110);
      chk(32'(freq_hold), 32'h0);
      wr(8'h04, 32'h0);
      smp(16'h0f00, 16'h0, 3'b101);
      chk(32'(freq_hold), 32'h0);
      wr(8'h04, 32'h0ed8);
      wr(8'h08, 32'h1);
      smp(16'h0f00, 16'h0, 3'b101);
      chk({freq_hold, decel_regulate}, 2'b01);
      wr(8'h08, 32'h0);
      $display("Test overvoltage stall done");
      smp(16'h0800, 16'h00b5, 3'b110);
      chk(32'(freq_hold), 32'h1);
      smp(16'h0800, 16'h00b4, 3'b110);
      chk(32'(freq_hold), 32'h0);
      wr(8'h0c, 32'h64);
      smp(16'h0800, 16'h0065, 3'b110);
      chk(32'(freq_hold), 32'h1);
      smp(16'h0800, 16'h00b5, 3'b100);
      chk({freq_hold, freq_lower}, 2'b01);
      smp(16'h0800, 16'h00b4, 3'b100);
      chk(32'(freq_lower), 32'h0);
      rd(8'h18, 32'h1c);
      wr(8'h1c, 32'h10);
      chk(32'(irq), 32'h1);
      wr(8'h18, 32'h1c);
      chk(32'(irq), 32'h0);
      $display("Test current stall done");
      for (int i = 0; i < 6; i++) begin
         wr(8'h14, 32'(i));
         chk({stall_ramp_auto, stall_ramp_set}, 4'(i) | ((i == 5) ? 4'h8 : 4'h0));
      end
      wr(8'h14, 32'h6);
      rd(8'h14, 32'h5);
      $display("Test ramp select done");
      hv_class <= 1'b1;
      arst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(8'h00, 32'h0e10);
      rd(8'h04, 32'h1db0);
      rd(8'h14, 32'h0);
      wr(8'h00, 32'h0100);
      rd(8'h00, 32'h0bb8);
      wr(8'h04, 32'hffff);
      rd(8'h04, 32'h2328);
      $display("Test higher class done");
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
